// ---- agcpm_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module agcpm_asserts (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Memory interface
    input wire logic memBusActive,
    input wire logic idleBusDriveBit,
    input wire logic memCtrlDriveEnN,
    input wire logic [15:0] memAddress,
    // Clock output
    input wire logic systemMasterClock,
    input wire logic bufferedClockOut,
    input wire logic bufferedClockOutEnN,
    input wire logic [2:0] clockOutSourceSelect,
    // Shared pins
    input wire logic [15:0] pinPortMode,
    input wire logic [15:0] portDirOut,
    input wire logic [15:0] portAPullupReg,
    input wire logic [15:0] pinOut,
    input wire logic [15:0] pinOutEnN,
    input wire logic [15:0] pinPullupEn
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_idle; !memBusActive && !idleBusDriveBit; endsequence
    property p_off; clockOutSourceSelect == 3'h0 |=> !bufferedClockOut; endproperty
    a_off: assert property (p_off) else $error("clock out on");
    property p_mst; clockOutSourceSelect == 3'h1 |=> bufferedClockOut == $past(systemMasterClock);
    endproperty
    a_mst: assert property (p_mst) else $error("clock out source");
    property p_flt; s_idle |=> memCtrlDriveEnN; endproperty
    a_flt: assert property (p_flt) else $error("idle bus driven");
    property p_drv; idleBusDriveBit |=> !memCtrlDriveEnN; endproperty
    a_drv: assert property (p_drv) else $error("idle bus floats");
    property p_rst; disable iff (1'b0) reset |=> bufferedClockOutEnN && &pinOutEnN && &pinPullupEn;
    endproperty
    a_rst: assert property (p_rst) else $error("reset pin state");
    property p_adr; pinPortMode == 16'h0000 |=> pinOut == $past(memAddress); endproperty
    a_adr: assert property (p_adr) else $error("address pins");
    property p_dir; pinPortMode == 16'hFFFF |=> pinOutEnN == ~$past(portDirOut); endproperty
    a_dir: assert property (p_dir) else $error("port direction");
    property p_pul; !portAPullupReg[8] |=> !pinPullupEn[0]; endproperty
    a_pul: assert property (p_pul) else $error("pull-up on");
endmodule
bind agcpm_pin_mux agcpm_asserts u_chk (
    .sys_clk(sys_clk), .reset(reset), .memBusActive(memBusActive),
    .idleBusDriveBit(idleBusDriveBit), .memCtrlDriveEnN(memCtrlDriveEnN),
    .memAddress(memAddress), .systemMasterClock(systemMasterClock),
    .bufferedClockOut(bufferedClockOut), .bufferedClockOutEnN(bufferedClockOutEnN),
    .clockOutSourceSelect(clockOutSourceSelect), .pinPortMode(pinPortMode),
    .portDirOut(portDirOut), .portAPullupReg(portAPullupReg), .pinOut(pinOut),
    .pinOutEnN(pinOutEnN), .pinPullupEn(pinPullupEn)
);
`default_nettype wire

// ---- agcpm_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module agcpm_mem_model (
    // Pin drive from the block
    input wire logic [15:0] pinOut,
    input wire logic [15:0] pinOutEnN,
    input wire logic [15:0] pinPullupEn,
    // Level that the memory side puts on released lines
    input wire logic [15:0] extLevel,
    // Level seen back at the pins
    output logic [15:0] pinIn
);
    // A released line follows its pull-up, else whatever the far end drives
    assign pinIn = (~pinOutEnN & pinOut) | (pinOutEnN & (pinPullupEn | extLevel));
endmodule
`default_nettype wire

// ---- agcpm_params.svh ----
// Overview of operation
// - Clock output pin sources off, master, bus, oscillator, prescaler or postscaler clock.
// - Idle-drive bit chooses float or drive of address and control outputs when bus idle.
// - Address 0-5 share port A bits 8-13, per-pin direction, address after reset.
// - Address 6-7 share port E bits 2-3, per-pin direction, address after reset.
// - Address 8-15 share port A bits 0-7, per-pin direction, address after reset.
// - Clearing a pin's matching pull-up register bit turns that pin's pull-up off.
// - Oscillator input clock drives core directly or serves as PLL reference.
`ifndef AGCPM_PARAMS_SVH
`define AGCPM_PARAMS_SVH
`define AGCPM_ADDR_WIDTH 16
`define AGCPM_PORT_WIDTH 16
`define AGCPM_SEL_WIDTH 3
`define AGCPM_PA_LO_BASE 8
`define AGCPM_PE_BASE 2
`define AGCPM_PA_HI_BASE 0
`define AGCPM_PULLUP_RESET 16'hFFFF
`define AGCPM_FUNC_RESET 16'h0000
`define AGCPM_IDLE_DRIVE_RESET 1'b0
`define AGCPM_PE_LINE 6
`define AGCPM_PA_HI_LINE 8
`define AGCPM_ENN_RESET 1'b1
`define AGCPM_CLKOUT_RESET 1'b0
`define AGCPM_MODE_RESET 1'b0
`define AGCPM_CORE_SEL_RESET 1'b1
`define AGCPM_OSC_RESET 1'b0
`define AGCPM_PIN_ENN_RESET 16'hFFFF
`define AGCPM_PIN_DATA_RESET 16'h0000
`endif

// ---- agcpm_pin_mux.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "agcpm_params.svh"
module agcpm_pin_mux
    import agcpm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Clock sources
    input wire logic systemMasterClock,
    input wire logic peripheralBusClock,
    input wire logic oscClock,
    input wire logic prescalerClock,
    input wire logic postscalerClock,
    input wire logic [2:0] clockOutSourceSelect,
    // Core clock selection
    input wire logic clockInputModeStrap,
    input wire logic oscDirectSelect,
    input wire logic pllClock,
    output logic oscToCore,
    output logic pllRefClock,
    output logic coreClockSel,
    output logic clockModeLatched,
    // Pin output
    output logic bufferedClockOut,
    output logic bufferedClockOutEnN,
    // External memory interface
    input wire logic [15:0] memAddress,
    input wire logic memBusActive,
    input wire logic idleBusDriveBit,
    output logic memCtrlDriveEnN,
    // Shared pin configuration, indexed by address line; pull-up registers by port bit
    input wire logic [15:0] pinPortMode,
    input wire logic [15:0] portDirOut,
    input wire logic [15:0] portDataOut,
    input wire logic [15:0] portAPullupReg,
    input wire logic [15:0] portEPullupReg,
    // Shared pins, indexed by address line
    input wire logic [15:0] pinIn,
    output logic [15:0] pinOut,
    output logic [15:0] pinOutEnN,
    output logic [15:0] pinPullupEn,
    output logic [15:0] portPinIn
);
    // ------------------------------------------------------------
    // Internal state
    // ------------------------------------------------------------
    logic clkOut_reg;
    logic clkOut_next;
    logic clkOutEnN_reg;
    logic clkOutEnN_next;
    logic modeLatched_reg;
    logic coreSel_reg;
    logic oscToCore_reg;
    logic oscToCore_next;
    logic pllRef_reg;
    logic pllRef_next;
    logic ctrlEnN_reg;
    logic ctrlEnN_next;
    logic addrDrive;
    logic [15:0] pinOut_reg;
    logic [15:0] pinEnN_reg;
    logic [15:0] pullEn_reg;
    logic [15:0] portIn_reg;
    // Per-line values, each bit driven by its own generate slice
    wire [15:0] pullBit;
    wire [15:0] pinOut_next;
    wire [15:0] pinEnN_next;
    wire [15:0] pullEn_next;

    // ------------------------------------------------------------
    // Clock output selection
    // ------------------------------------------------------------
    // Sources are sampled as data, so only clocks well below half of sys_clk come out whole
    always_comb begin
        clkOut_next = 1'b0;
        clkOutEnN_next = 1'b0;
        case (agcpm_clk_sel_type'(clockOutSourceSelect))
            AGCPM_CLK_MASTER: begin
                clkOut_next = systemMasterClock;
            end
            AGCPM_CLK_BUS: begin
                clkOut_next = peripheralBusClock;
            end
            AGCPM_CLK_OSC: begin
                clkOut_next = oscClock;
            end
            AGCPM_CLK_PRESCALER: begin
                clkOut_next = prescalerClock;
            end
            AGCPM_CLK_POSTSCALER: begin
                clkOut_next = postscalerClock;
            end
            default: begin
                // Off and the two unused codes keep the pin quiet and released
                clkOut_next = 1'b0;
                clkOutEnN_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clkOut_reg <= `AGCPM_CLKOUT_RESET;
            clkOutEnN_reg <= `AGCPM_ENN_RESET;
        end else begin
            clkOut_reg <= clkOut_next;
            clkOutEnN_reg <= clkOutEnN_next;
        end
    end

    assign bufferedClockOut = clkOut_reg;
    assign bufferedClockOutEnN = clkOutEnN_reg;

    // ------------------------------------------------------------
    // Oscillator routing
    // ------------------------------------------------------------
    always_comb begin
        oscToCore_next = pllClock;
        pllRef_next = oscClock;
        if (oscDirectSelect) begin
            // Direct mode starves the PLL reference so it cannot lock on a stale input
            oscToCore_next = oscClock;
            pllRef_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            coreSel_reg <= `AGCPM_CORE_SEL_RESET;
            oscToCore_reg <= `AGCPM_OSC_RESET;
            pllRef_reg <= `AGCPM_OSC_RESET;
        end else begin
            coreSel_reg <= oscDirectSelect;
            oscToCore_reg <= oscToCore_next;
            pllRef_reg <= pllRef_next;
        end
    end

    // The strap is a board level; it is only recorded here for software to read
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            modeLatched_reg <= `AGCPM_MODE_RESET;
        end else begin
            modeLatched_reg <= clockInputModeStrap;
        end
    end

    assign coreClockSel = coreSel_reg;
    assign oscToCore = oscToCore_reg;
    assign pllRefClock = pllRef_reg;
    assign clockModeLatched = modeLatched_reg;

    // ------------------------------------------------------------
    // Memory interface idle drive
    // ------------------------------------------------------------
    // Address and control lines float only when the bus is idle and idle drive is off
    assign addrDrive = memBusActive || idleBusDriveBit;
    assign ctrlEnN_next = !addrDrive;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrlEnN_reg <= `AGCPM_ENN_RESET;
        end else begin
            ctrlEnN_reg <= ctrlEnN_next;
        end
    end

    assign memCtrlDriveEnN = ctrlEnN_reg;

    // ------------------------------------------------------------
    // Shared pin selection
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < `AGCPM_ADDR_WIDTH; i++) begin : g_pin
            if (i < `AGCPM_PE_LINE) begin : g_pa_lo
                assign pullBit[i] = portAPullupReg[i + `AGCPM_PA_LO_BASE];
            end else if (i < `AGCPM_PA_HI_LINE) begin : g_pe
                assign pullBit[i] = portEPullupReg[i - `AGCPM_PE_LINE + `AGCPM_PE_BASE];
            end else begin : g_pa_hi
                assign pullBit[i] = portAPullupReg[i - `AGCPM_PA_HI_LINE + `AGCPM_PA_HI_BASE];
            end
            assign pinOut_next[i] = pinPortMode[i] ? portDataOut[i]
                : memAddress[i];
            // A pin owned by the address bus follows the idle drive choice
            assign pinEnN_next[i] = pinPortMode[i] ? !portDirOut[i] : !addrDrive;
            // Pull-up only on a released pin, so it never fights the output driver
            assign pullEn_next[i] = pullBit[i] && pinEnN_next[i];
        end
    endgenerate

    // ------------------------------------------------------------
    // Shared pin registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pinOut_reg <= `AGCPM_PIN_DATA_RESET;
            pinEnN_reg <= `AGCPM_PIN_ENN_RESET;
        end else begin
            pinOut_reg <= pinOut_next;
            pinEnN_reg <= pinEnN_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pullEn_reg <= `AGCPM_PULLUP_RESET;
        end else begin
            pullEn_reg <= pullEn_next;
        end
    end

    // Pin levels are sampled in both modes; software reads them only in port mode
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            portIn_reg <= `AGCPM_PIN_DATA_RESET;
        end else begin
            portIn_reg <= pinIn;
        end
    end

    assign pinOut = pinOut_reg;
    assign pinOutEnN = pinEnN_reg;
    assign pinPullupEn = pullEn_reg;
    assign portPinIn = portIn_reg;
endmodule
`default_nettype wire

// ---- agcpm_pkg.sv ----
`include "agcpm_params.svh"
package agcpm_pkg;
    typedef enum logic [2:0] {
        AGCPM_CLK_OFF,
        AGCPM_CLK_MASTER,
        AGCPM_CLK_BUS,
        AGCPM_CLK_OSC,
        AGCPM_CLK_PRESCALER,
        AGCPM_CLK_POSTSCALER
    } agcpm_clk_sel_type;
endpackage

// ---- test_address_gpio_clock_pin_mux.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; $display("Error %0t %h %h", $time, a, e); end end
module test_address_gpio_clock_pin_mux;
    logic sys_clk = 0, reset = 1, clockInputModeStrap = 0, oscDirectSelect = 1, pllClock = 0;
    logic systemMasterClock, peripheralBusClock, oscClock, prescalerClock, postscalerClock;
    logic memBusActive = 0, idleBusDriveBit = 0, oscToCore, pllRefClock, coreClockSel;
    logic clockModeLatched, bufferedClockOut, bufferedClockOutEnN, memCtrlDriveEnN;
    logic [2:0] clockOutSourceSelect = 0;
    logic [4:0] src = 0;
    logic [15:0] memAddress = 0, pinPortMode = 0, portDirOut = 0, portDataOut = 0, extLevel = 0;
    logic [15:0] portAPullupReg = 16'hFFFF, portEPullupReg = 16'hFFFF, pinIn, pinOut, pinOutEnN;
    logic [15:0] pinPullupEn, portPinIn;
    int n_errors = 0, total_checks = 0;
    assign {postscalerClock, prescalerClock, oscClock, peripheralBusClock, systemMasterClock} = src;
    agcpm_pin_mux uut (
        .sys_clk(sys_clk), .reset(reset), .systemMasterClock(systemMasterClock),
        .peripheralBusClock(peripheralBusClock), .oscClock(oscClock),
        .prescalerClock(prescalerClock), .postscalerClock(postscalerClock),
        .clockOutSourceSelect(clockOutSourceSelect), .clockInputModeStrap(clockInputModeStrap),
        .oscDirectSelect(oscDirectSelect), .pllClock(pllClock), .oscToCore(oscToCore),
        .pllRefClock(pllRefClock), .coreClockSel(coreClockSel),
        .clockModeLatched(clockModeLatched), .bufferedClockOut(bufferedClockOut),
        .bufferedClockOutEnN(bufferedClockOutEnN), .memAddress(memAddress),
        .memBusActive(memBusActive), .idleBusDriveBit(idleBusDriveBit),
        .memCtrlDriveEnN(memCtrlDriveEnN), .pinPortMode(pinPortMode),
        .portDirOut(portDirOut), .portDataOut(portDataOut), .portAPullupReg(portAPullupReg),
        .portEPullupReg(portEPullupReg), .pinIn(pinIn), .pinOut(pinOut),
        .pinOutEnN(pinOutEnN), .pinPullupEn(pinPullupEn), .portPinIn(portPinIn)
    );
    agcpm_mem_model mem (
        .pinOut(pinOut), .pinOutEnN(pinOutEnN), .pinPullupEn(pinPullupEn),
        .extLevel(extLevel), .pinIn(pinIn)
    );
    always #5 sys_clk = ~sys_clk;
    task tick; @(posedge sys_clk); #1; endtask
    task t_clk; for (int s = 0; s < 8; s++) begin
        clockOutSourceSelect = s[2:0];
        src = (s inside {[1:5]}) ? 5'h01 << (s - 1) : 5'h1f;
        tick;
        `CHK(bufferedClockOut, s inside {[1:5]})
        `CHK(bufferedClockOutEnN, !(s inside {[1:5]}))
    end $display("clock out test done"); endtask
    task t_bus; for (int k = 0; k < 4; k++) begin
        {memBusActive, idleBusDriveBit} = k[1:0];
        memAddress = 16'hA5C3 ^ k[15:0];
        tick;
        `CHK(memCtrlDriveEnN, k == 0)
        `CHK(pinOutEnN, {16{k == 0}})
        `CHK(pinOut, 16'hA5C3 ^ k[15:0])
        `CHK(pinPullupEn, {16{k == 0}})
    end $display("bus drive test done"); endtask
    task t_port;
        pinPortMode = 16'hFFFF; portDirOut = 16'hFF00; portDataOut = 16'h1234;
        portAPullupReg = 16'hFEFE; portEPullupReg = 16'hFFFB;
        extLevel = 16'h0041;
        tick;
        `CHK(pinOutEnN, 16'h00FF)
        `CHK(pinOut, 16'h1234)
        `CHK(pinPullupEn, 16'h00BE)
        tick;
        `CHK(portPinIn, 16'h12FF)
        pinPortMode = 16'h0000;
        $display("port mode test done");
    endtask
    task t_osc;
        oscDirectSelect = 0; src = 5'h04; clockInputModeStrap = 1;
        tick;
        `CHK(pllRefClock, 1'b1)
        `CHK(coreClockSel, 1'b0)
        `CHK(clockModeLatched, 1'b1)
        `CHK(oscToCore, 1'b0)
        oscDirectSelect = 1;
        tick;
        `CHK(oscToCore, 1'b1)
        `CHK(pllRefClock, 1'b0)
        `CHK(coreClockSel, 1'b1)
        $display("oscillator test done");
    endtask
    task t_rst;
        reset = 1;
        repeat (2) tick;
        `CHK({bufferedClockOutEnN, pinOutEnN, pinPullupEn}, 33'h1_FFFF_FFFF)
        `CHK({bufferedClockOut, memCtrlDriveEnN, pinOut, portPinIn}, 34'h1_0000_0000)
        `CHK({coreClockSel, clockModeLatched}, 2'h2)
        reset = 0;
        tick;
        `CHK(memCtrlDriveEnN, !(memBusActive || idleBusDriveBit))
        $display("reset test done");
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin repeat (500) @(posedge sys_clk); n_errors++; wrap_up; end
    initial begin
        repeat (14) tick;
        t_rst;
        t_clk; t_bus; t_port;
        t_rst;
        t_osc;
        wrap_up;
    end
endmodule
`default_nettype wire
